// File: hw/pmwc_top.sv
// power mode and wake controller: idle/sleep entry, wake triggers, start delays, watchdog
// assumes an apb master on mclk, synchronous status inputs and one-cycle wake sources
`timescale 1ns/1ps
`include "pmwc_regs.svh"

// Contract
// - internal-oscillator idle stops cpu clock, peripherals keep running on internal oscillator
// - sleep with idle select set and clock select zero enters internal-oscillator idle
// - switch to internal oscillator stops primary oscillator and clears startup status
// - wake from idle leaves idle select and clock select untouched
// - internal rc stays on while watchdog or clock monitor is enabled
// - only interrupt, reset or watchdog time-out end sleep or idle
// - enabled interrupt flag rising starts the exit sequence
// - interrupt wake branches to vector only when global enable bit is set
// - every wake waits the fixed cpu start delay, then execution resumes
// - wake from internal-oscillator idle resumes cpu on internal rc
// - watchdog time-out in sleep or idle only wakes, no reset
// - watchdog time-out while running produces a watchdog reset
// - sleep or watchdog clear command clears watchdog counter
// - clock loss with monitor enabled clears watchdog counter
// - reset ending sleep or idle forces running from internal rc
// - wake from primary-clock idle skips oscillator startup timer
// - external clock modes skip startup timer, start delay still applies
module pmwc_top #(
  parameter int CSD_CYCLES  = `PMWC_CSD_CYCLES,
  parameter int WARM_CYCLES = `PMWC_WARM_CYCLES,
  parameter int WDT_CYCLES  = `PMWC_WDT_CYCLES,
  parameter int IRQ_SRCS    = 8
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [IRQ_SRCS-1:0] irq_flag,
  input  wire logic [IRQ_SRCS-1:0] irq_enable,
  input  wire logic                clock_lost,
  output logic                     cpu_clk_en,
  output logic                     periph_clk_en,
  output logic                     pri_osc_en,
  output logic                     internal_rc_clock_en,
  output logic                     cpu_on_internal_rc,
  output logic                     branch_to_vector,
  output logic                     watchdog_reset,
  output logic                     irq
);

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  pmwc_pkg::pmwc_state_t state;
  pmwc_pkg::pmwc_state_t next_state;
  pmwc_pkg::pmwc_wake_t  wake_cause;
  logic [31:0]           ctrl;
  logic                  osc_startup_status;
  logic [`PMWC_IRQ_W-1:0] irq_status;
  logic [`PMWC_IRQ_W-1:0] irq_mask;
  logic [IRQ_SRCS-1:0]   flag_q;
  logic                  from_primary_clock_idle_mode;

  logic idle_on_sleep_select;
  logic wdt_en;
  logic fscm_en;
  logic ext_clk;
  pmwc_pkg::pmwc_clk_t system_clock_select;
  assign idle_on_sleep_select = ctrl[`PMWC_CTRL_IDLE];
  assign system_clock_select  = pmwc_pkg::pmwc_clk_t'(ctrl[`PMWC_CTRL_CKSEL_HI:`PMWC_CTRL_CKSEL_LO]);
  assign wdt_en               = ctrl[`PMWC_CTRL_WDTEN];
  assign fscm_en              = ctrl[`PMWC_CTRL_FSCMEN];
  assign ext_clk              = ctrl[`PMWC_CTRL_EXTCK];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic cmd_sleep;
  logic cmd_wdclr;
  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;
  assign cmd_sleep  = wr_acc && paddr == `PMWC_OFF_CMD && pwdata[`PMWC_CMD_SLEEP] && state == pmwc_pkg::PMWC_RUN;
  assign cmd_wdclr  = wr_acc && paddr == `PMWC_OFF_CMD && pwdata[`PMWC_CMD_WDCLR];

  function automatic logic pmwc_mapped(input logic [11:0] a);
    pmwc_mapped = a == `PMWC_OFF_CTRL || a == `PMWC_OFF_CMD || a == `PMWC_OFF_STATUS ||
                  a == `PMWC_OFF_IRQ_ST || a == `PMWC_OFF_IRQ_MSK;
  endfunction

  // pready answers in the first access cycle, so no wait states
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !pmwc_mapped(paddr);
    end
  end

  // ----------------------------------------
  // wake detection
  // ----------------------------------------
  logic irq_wake;
  logic wdt_timeout;
  logic in_pm_mode;
  // the rising edge of an enabled flag is the wake moment, a flag already high does not count
  assign irq_wake   = |(irq_flag & ~flag_q & irq_enable);
  assign in_pm_mode = state == pmwc_pkg::PMWC_IDLE || state == pmwc_pkg::PMWC_SLEEP;

  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= irq_flag;
    end
  end

  // ----------------------------------------
  // counters
  // ----------------------------------------
  logic csd_load;
  logic csd_done;
  logic csd_kick;
  logic warm_load;
  logic warm_done;
  logic wdt_clear;
  logic wdt_load;
  logic wdt_en_q;

  // watchdog restarts on sleep, clear command or clock loss under the monitor
  assign wdt_clear = cmd_sleep || cmd_wdclr || (fscm_en && clock_lost);
  assign wdt_load  = wdt_clear || wdt_timeout || (wdt_en && !wdt_en_q);

  always_ff @(posedge mclk) begin
    if (rst) begin
      wdt_en_q <= 1'b0;
    end else begin
      wdt_en_q <= wdt_en;
    end
  end

  // the delay counter is cleared by reset, so the first free cycle must load it or reset-wake hangs
  always_ff @(posedge mclk) begin
    if (rst) begin
      csd_kick <= 1'b1;
    end else begin
      csd_kick <= 1'b0;
    end
  end

  pmwc_down_counter #(.WIDTH(16)) u_csd (
    .mclk       (mclk),
    .rst        (rst),
    .load       (csd_load),
    .load_value (16'(CSD_CYCLES)),
    .run        (1'b1),
    .done       (csd_done)
  );

  pmwc_down_counter #(.WIDTH(16)) u_warm (
    .mclk       (mclk),
    .rst        (rst),
    .load       (warm_load),
    .load_value (16'(WARM_CYCLES)),
    .run        (1'b1),
    .done       (warm_done)
  );

  pmwc_down_counter #(.WIDTH(24)) u_wdt (
    .mclk       (mclk),
    .rst        (rst),
    .load       (wdt_load),
    .load_value (24'(WDT_CYCLES)),
    .run        (wdt_en),
    .done       (wdt_timeout)
  );

  // ----------------------------------------
  // power mode sequencer
  // ----------------------------------------
  logic any_wake;
  logic skip_warm;
  assign any_wake = irq_wake || (wdt_en && wdt_timeout);
  // primary-clock idle keeps the oscillator alive and external clocks need no start-up
  assign skip_warm = from_primary_clock_idle_mode || ext_clk || system_clock_select != pmwc_pkg::PMWC_CLK_PRI;

  always_comb begin
    next_state = state;
    csd_load   = 1'b0;
    warm_load  = 1'b0;
    unique case (state)
      pmwc_pkg::PMWC_RUN: begin
        if (cmd_sleep) begin
          next_state = idle_on_sleep_select ? pmwc_pkg::PMWC_IDLE : pmwc_pkg::PMWC_SLEEP;
        end
      end
      pmwc_pkg::PMWC_IDLE, pmwc_pkg::PMWC_SLEEP: begin
        if (any_wake) begin
          if (state == pmwc_pkg::PMWC_SLEEP && !skip_warm) begin
            next_state = pmwc_pkg::PMWC_WARM;
            warm_load  = 1'b1;
          end else begin
            next_state = pmwc_pkg::PMWC_CSD;
            csd_load   = 1'b1;
          end
        end
      end
      pmwc_pkg::PMWC_WARM: begin
        if (warm_done) begin
          next_state = pmwc_pkg::PMWC_CSD;
          csd_load   = 1'b1;
        end
      end
      pmwc_pkg::PMWC_CSD, pmwc_pkg::PMWC_RSTW: begin
        csd_load = csd_kick && state == pmwc_pkg::PMWC_RSTW;
        if (csd_done) begin
          next_state = pmwc_pkg::PMWC_RUN;
        end
      end
      default: next_state = pmwc_pkg::PMWC_RUN;
    endcase
  end

  // reset while asleep is itself the wake: the delay still runs, then run on internal rc
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= pmwc_pkg::PMWC_RSTW;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      from_primary_clock_idle_mode <= 1'b0;
    end else if (cmd_sleep) begin
      from_primary_clock_idle_mode <= idle_on_sleep_select && system_clock_select == pmwc_pkg::PMWC_CLK_PRI;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_cause <= pmwc_pkg::PMWC_WK_RST;
    end else if (in_pm_mode && irq_wake) begin
      wake_cause <= pmwc_pkg::PMWC_WK_IRQ;
    end else if (in_pm_mode && any_wake) begin
      wake_cause <= pmwc_pkg::PMWC_WK_WDT;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic on_int_osc;
  assign on_int_osc = system_clock_select == pmwc_pkg::PMWC_CLK_INT_OSC ||
                      system_clock_select == pmwc_pkg::PMWC_CLK_INTOS2;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_clk_en           <= 1'b0;
      periph_clk_en        <= 1'b0;
      pri_osc_en           <= 1'b0;
      internal_rc_clock_en <= 1'b1;
      cpu_on_internal_rc   <= 1'b1;
    end else begin
      cpu_clk_en           <= next_state == pmwc_pkg::PMWC_RUN;
      periph_clk_en        <= next_state != pmwc_pkg::PMWC_SLEEP;
      // primary oscillator off whenever the source is the internal block, or in plain sleep
      pri_osc_en           <= !on_int_osc && next_state != pmwc_pkg::PMWC_SLEEP;
      internal_rc_clock_en <= on_int_osc || wdt_en || fscm_en || next_state != pmwc_pkg::PMWC_SLEEP;
      cpu_on_internal_rc   <= on_int_osc || wake_cause == pmwc_pkg::PMWC_WK_RST;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      branch_to_vector <= 1'b0;
    end else begin
      branch_to_vector <= csd_done && wake_cause == pmwc_pkg::PMWC_WK_IRQ && ctrl[`PMWC_CTRL_GLBIE];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wdt_en && wdt_timeout && state == pmwc_pkg::PMWC_RUN;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_startup_status <= 1'b0;
    end else if (on_int_osc) begin
      osc_startup_status <= 1'b0;
    end else if (warm_done || (skip_warm && state == pmwc_pkg::PMWC_RUN)) begin
      osc_startup_status <= 1'b1;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // ctrl is only written by software; the wake path never touches it
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= `PMWC_CTRL_RST;
    end else if (wr_acc && paddr == `PMWC_OFF_CTRL) begin
      ctrl <= pwdata & 32'h0000_0787;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_mask <= '0;
    end else if (wr_acc && paddr == `PMWC_OFF_IRQ_MSK) begin
      irq_mask <= pwdata[`PMWC_IRQ_W-1:0];
    end
  end

  logic [`PMWC_IRQ_W-1:0] irq_events;
  assign irq_events = {fscm_en && clock_lost, wdt_en && wdt_timeout && state == pmwc_pkg::PMWC_RUN,
                       state == pmwc_pkg::PMWC_CSD && csd_done};

  // a read clears the status, but an event in the same cycle survives it
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_status <= '0;
    end else if (rd_acc && paddr == `PMWC_OFF_IRQ_ST) begin
      irq_status <= irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `PMWC_OFF_CTRL:    prdata <= ctrl;
        `PMWC_OFF_STATUS:  prdata <= {20'h0_0000, 2'(wake_cause), 4'(state[5:2]), state[1:0],
                                      pri_osc_en, internal_rc_clock_en, cpu_clk_en, osc_startup_status};
        `PMWC_OFF_IRQ_ST:  prdata <= {29'h0000_0000, irq_status};
        `PMWC_OFF_IRQ_MSK: prdata <= {29'h0000_0000, irq_mask};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: hw/pmwc_regs.svh
// register map, field positions, reset values and timing counts of the power mode / wake controller
// assumes a 32-bit apb slave with word-aligned registers
`ifndef PMWC_REGS_SVH
`define PMWC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMWC_OFF_CTRL    12'h000
`define PMWC_OFF_CMD     12'h004
`define PMWC_OFF_STATUS  12'h008
`define PMWC_OFF_IRQ_ST  12'h00C
`define PMWC_OFF_IRQ_MSK 12'h010

// ----------------------------------------
// control fields
// ----------------------------------------
`define PMWC_CTRL_IDLE   0
`define PMWC_CTRL_CKSEL_LO 1
`define PMWC_CTRL_CKSEL_HI 2
`define PMWC_CTRL_GLBIE  7
`define PMWC_CTRL_WDTEN  8
`define PMWC_CTRL_FSCMEN 9
`define PMWC_CTRL_EXTCK  10
`define PMWC_CTRL_RST    32'h0000_0000

// ----------------------------------------
// command bits (write one to act)
// ----------------------------------------
`define PMWC_CMD_SLEEP   0
`define PMWC_CMD_WDCLR   1

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define PMWC_IRQ_WAKE    0
`define PMWC_IRQ_WDTRST  1
`define PMWC_IRQ_CKLOSS  2
`define PMWC_IRQ_W       3

// ----------------------------------------
// timing
// ----------------------------------------
`define PMWC_CSD_CYCLES  16
`define PMWC_WARM_CYCLES 1024
`define PMWC_WDT_CYCLES  4096

`endif

// File: hw/pmwc_pkg.sv
// types shared by the power mode / wake controller
// assumes nothing beyond a systemverilog compiler
package pmwc_pkg;

  typedef enum logic [5:0] {
    PMWC_RUN   = 6'b000001,
    PMWC_IDLE  = 6'b000010,
    PMWC_SLEEP = 6'b000100,
    PMWC_WARM  = 6'b001000,
    PMWC_CSD   = 6'b010000,
    PMWC_RSTW  = 6'b100000
  } pmwc_state_t;

  // system clock select encoding; zero selects the internal oscillator block
  typedef enum logic [1:0] {
    PMWC_CLK_INT_OSC = 2'h0,
    PMWC_CLK_PRI     = 2'h1,
    PMWC_CLK_SEC     = 2'h2,
    PMWC_CLK_INTOS2  = 2'h3
  } pmwc_clk_t;

  typedef enum logic [1:0] {
    PMWC_WK_NONE = 2'h0,
    PMWC_WK_IRQ  = 2'h1,
    PMWC_WK_WDT  = 2'h2,
    PMWC_WK_RST  = 2'h3
  } pmwc_wake_t;

endpackage

// File: hw/pmwc_down_counter.sv
// loadable down-counter with a done flag, used for start delays and the watchdog
// assumes load and clear are single-cycle requests from the owner
`timescale 1ns/1ps
module pmwc_down_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             run,
  output logic                  done
);

  logic [WIDTH-1:0] count;
  logic             armed;

  always_ff @(posedge mclk) begin
    if (rst || load) begin
      count <= rst ? '0 : load_value;
    end else if (run && count != '0) begin
      count <= count - WIDTH'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (load) begin
      armed <= 1'b1;
    end else if (run && count == WIDTH'(1)) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || load) begin
      done <= 1'b0;
    end else begin
      done <= armed && run && count == WIDTH'(1);
    end
  end

endmodule

// File: tb/pmwc_chk.sv
// assertion checker of the power mode / wake controller
// assumes it is bound into pmwc_top: one clock, synchronous active-high reset
`timescale 1ns/1ps
module pmwc_chk #(
  parameter int CSD_CYCLES = 16,
  parameter int IRQ_SRCS   = 8
) (
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pready,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [IRQ_SRCS-1:0] irq_flag,
  input wire logic [IRQ_SRCS-1:0] irq_enable,
  input wire logic                clock_lost,
  input wire logic                cpu_clk_en,
  input wire logic                periph_clk_en,
  input wire logic                pri_osc_en,
  input wire logic                internal_rc_clock_en,
  input wire logic                cpu_on_internal_rc,
  input wire logic                branch_to_vector,
  input wire logic                watchdog_reset
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic        wr_ok;
  int unsigned wake_age;
  assign wr_ok = psel && penable && pwrite && pready;
  // shadow of the control word, updated at completed writes only
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= 32'h0000_0000;
    end else if (wr_ok && paddr == 12'h000) begin
      ctrl_q <= pwdata;
    end
  end
  // age of an interrupt wake; restarts whenever the cpu runs
  always_ff @(posedge mclk) begin
    if (rst || cpu_clk_en) begin
      wake_age <= 0;
    end else if ($rose(|(irq_flag & irq_enable)) || wake_age != 0) begin
      wake_age <= wake_age + 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_sleep_stops_cpu: assert property (wr_ok && paddr == 12'h004 && pwdata[0] && cpu_clk_en
    |-> ##[1:3] !cpu_clk_en) else $error("sleep did not stop the cpu clock");
  a_idle_periph_on: assert property (ctrl_q[0] && $past(ctrl_q[0]) |-> periph_clk_en)
    else $error("peripheral clock off with idle select set");
  a_int_osc_pri_off: assert property (ctrl_q[2:1] == 2'h0 && $past(ctrl_q[2:1]) == 2'h0 |-> !pri_osc_en)
    else $error("primary oscillator on while internal oscillator selected");
  a_rc_keep_alive: assert property ((ctrl_q[8] || ctrl_q[9]) && $past(ctrl_q[8] || ctrl_q[9])
    |-> internal_rc_clock_en) else $error("internal rc stopped with watchdog or monitor on");
  a_wake_min_delay: assert property ($rose(cpu_clk_en) && wake_age != 0 |-> wake_age > CSD_CYCLES)
    else $error("cpu started before the start delay");
  a_wake_max_delay: assert property (wake_age < 40)
    else $error("enabled interrupt did not wake the cpu in time");
  a_branch_with_gie: assert property (branch_to_vector |-> ctrl_q[7] ##[0:2] cpu_clk_en)
    else $error("branch without global enable or outside wake end");
  a_wdt_reset_run: assert property (watchdog_reset |-> $past(cpu_clk_en) ##1 !watchdog_reset)
    else $error("watchdog reset outside run or longer than one cycle");
  a_clear_holds_wdt: assert property (wr_ok && paddr == 12'h004 && pwdata[1]
    |=> !watchdog_reset [*8]) else $error("watchdog fired right after a clear");
  a_loss_holds_wdt: assert property (clock_lost && ctrl_q[9] |=> !watchdog_reset [*8])
    else $error("watchdog fired right after a clock loss");
  a_wake_on_rc: assert property ($rose(cpu_clk_en) && ctrl_q[2:1] == 2'h0 |-> ##[0:1] cpu_on_internal_rc)
    else $error("cpu not on internal rc after wake");
endmodule

bind pmwc_top pmwc_chk #(.CSD_CYCLES(CSD_CYCLES), .IRQ_SRCS(IRQ_SRCS)) u_chk (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .paddr(paddr), .pwdata(pwdata), .irq_flag(irq_flag), .irq_enable(irq_enable), .clock_lost(clock_lost),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .pri_osc_en(pri_osc_en),
  .internal_rc_clock_en(internal_rc_clock_en), .cpu_on_internal_rc(cpu_on_internal_rc),
  .branch_to_vector(branch_to_vector), .watchdog_reset(watchdog_reset)
);

// File: tb/pmwc_top_bench.sv
// self-checking bench of the power mode / wake controller
// assumes pmwc_top with shortened delays and the checker bound into it
`timescale 1ns/1ps
module pmwc_top_bench;
  localparam int CSD = 4;
  localparam int WARM = 8;
  localparam int WDT = 20;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } pmwc_row_t;
  typedef struct packed {
    logic [31:0] ctrl;
    int          lo;
    int          hi;
  } pmwc_wake_row_t;
  logic           mclk = 1'b0;
  logic           rst, psel, penable, pwrite, clock_lost, e;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, q, cur;
  logic           pready, pslverr, irq;
  logic [7:0]     irq_flag, irq_enable;
  logic           cpu_clk_en, periph_clk_en, pri_osc_en, internal_rc_clock_en;
  logic           cpu_on_internal_rc, branch_to_vector, watchdog_reset;
  int             err_count = 0;
  int             checks_done = 0;
  int             br_cnt = 0;
  int             wd_cnt = 0;
  int             n;
  pmwc_row_t      rows [5] = '{'{12'h000, 32'hFFFF_F87F, 32'h0000_0007, 1'b0},
                               '{12'h010, 32'hFFFF_FFFF, 32'h0000_0007, 1'b0},
                               '{12'h020, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
                               '{12'hFFC, 32'h1234_5678, 32'h0000_0000, 1'b1},
                               '{12'h000, 32'h0000_0000, 32'h0000_0000, 1'b0}};
  // sleep on primary needs the startup timer; external clock and primary idle skip it
  pmwc_wake_row_t wk [4] = '{'{32'h0000_0002, WARM + CSD, WARM + CSD + 8}, '{32'h0000_0402, CSD, CSD + 4},
                             '{32'h0000_0083, CSD, CSD + 4}, '{32'h0000_0081, CSD, CSD + 4}};

  pmwc_top #(.CSD_CYCLES(CSD), .WARM_CYCLES(WARM), .WDT_CYCLES(WDT)) uut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_flag(irq_flag),
    .irq_enable(irq_enable), .clock_lost(clock_lost), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .pri_osc_en(pri_osc_en), .internal_rc_clock_en(internal_rc_clock_en), .cpu_on_internal_rc(cpu_on_internal_rc),
    .branch_to_vector(branch_to_vector), .watchdog_reset(watchdog_reset), .irq(irq)
  );

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (branch_to_vector === 1'b1) br_cnt++;
    if (watchdog_reset === 1'b1) wd_cnt++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic stall(input string what);
    $display("mismatch %s expected done seen timeout", what);
    err_count++;
    report_and_stop();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) stall("apb_ready");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cpu(input int lim);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (cpu_clk_en !== 1'b1) stall("cpu_start");
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("rc_en_in_reset", 1, internal_rc_clock_en);
    chk("cpu_rc_in_reset", 1, cpu_on_internal_rc);
    rst <= 1'b0;
    wait_cpu(50);
    chk("reset_start_delay", 1, n >= CSD + 1 && n <= CSD + 4);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    irq_flag = 8'h00;
    irq_enable = 8'h00;
    clock_lost = 1'b0;
    do_reset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      chk("write_err", rows[i].err, e);
      apb(1'b0, rows[i].addr, 32'h0000_0000);
      chk("read_data", rows[i].rdata, q);
      chk("read_err", rows[i].err, e);
    end
    cur = 32'h0000_0000;
    foreach (wk[i]) begin
      apb(1'b1, 12'h000, cur | (wk[i].ctrl & 32'h0000_0001));
      apb(1'b1, 12'h000, wk[i].ctrl);
      cur = wk[i].ctrl;
      apb(1'b1, 12'h004, 32'h0000_0001);
      repeat (3) @(posedge mclk);
      chk("cpu_halted", 0, cpu_clk_en);
      chk("periph_clk", cur[0], periph_clk_en);
      if (cur[2:1] == 2'h0) chk("pri_osc_off", 0, pri_osc_en);
      irq_flag <= 8'h01;
      repeat (6) @(posedge mclk);
      chk("disabled_src_wake", 0, cpu_clk_en);
      irq_flag <= 8'h00;
      irq_enable <= 8'h01;
      @(posedge mclk);
      br_cnt = 0;
      irq_flag <= 8'h01;
      wait_cpu(60);
      chk("wake_delay", 1, n >= wk[i].lo && n <= wk[i].hi);
      repeat (2) @(posedge mclk);
      chk("branch_count", cur[7], br_cnt);
      if (cur[2:1] == 2'h0) chk("cpu_on_rc", 1, cpu_on_internal_rc);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("ctrl_after_wake", cur, q);
      apb(1'b0, 12'h008, 32'h0000_0000);
      if (cur[2:1] == 2'h0) chk("osc_status_clear", 0, q[0]);
      chk("irq_raised", 1, irq);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("wake_status", 1, q[0]);
      repeat (2) @(posedge mclk);
      chk("irq_cleared", 0, irq);
      irq_flag <= 8'h00;
      irq_enable <= 8'h00;
    end
    // watchdog with monitor on, mask off so the line must stay low
    apb(1'b1, 12'h010, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0302);
    wd_cnt = 0;
    repeat (3) begin
      repeat (8) @(posedge mclk);
      apb(1'b1, 12'h004, 32'h0000_0002);
    end
    repeat (3) begin
      repeat (10) @(posedge mclk);
      clock_lost <= 1'b1;
      @(posedge mclk);
      clock_lost <= 1'b0;
    end
    chk("wdt_held", 0, wd_cnt);
    apb(1'b1, 12'h004, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk("rc_kept", 1, internal_rc_clock_en);
    wait_cpu(80);
    chk("wdt_wake_no_reset", 0, wd_cnt);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("wake_cause", 2, q[11:10]);
    n = 0;
    while (wd_cnt == 0 && n < 80) begin
      @(posedge mclk);
      n++;
    end
    if (wd_cnt == 0) stall("wdt_timeout");
    chk("wdt_run_reset", 1, wd_cnt);
    repeat (2) @(posedge mclk);
    chk("irq_masked", 0, irq);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("wdt_status", 1, q[1]);
    // reset while asleep on the primary clock
    do_reset();
    apb(1'b1, 12'h000, 32'h0000_0002);
    apb(1'b1, 12'h004, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    do_reset();
    chk("rc_after_reset", 1, cpu_on_internal_rc);
    report_and_stop();
  end
endmodule
